// ===== shared/timer_status_irq_cfg.svh
/*
 * constants of the timer status and interrupt-enable register bank
 * assumes: included by bare name after the package
 */
`ifndef TIMER_STATUS_IRQ_CFG_SVH
`define TIMER_STATUS_IRQ_CFG_SVH

// ==========================================================
// address map: bits 6..4 pick the channel, bits 3..0 the register
`define TSI_CHANNELS      5
`define TSI_ADDR_TOP_BIT  1'h0
`define TSI_OFF_FLAGS     4'h0
`define TSI_OFF_ENABLES   4'h1
`define TSI_OFF_WIDE_LO   4'h2
`define TSI_OFF_WIDE_HI   4'hb

// ==========================================================
// reset values and field layout
`define TSI_FLAGS_RESET   8'hf8
`define TSI_ENABLES_RESET 8'hf8
`define TSI_RESERVED_ONES 5'h1f
`define TSI_BIT_WRAP      2
`define TSI_BIT_EVB       1
`define TSI_BIT_EVA       0

// ==========================================================
// channel features
`define TSI_PHASE_CHANNEL 2
`define TSI_DMA_CHANNELS  5'h0f
`define TSI_COMPLEMENTARY 2'h2

`endif

// ===== shared/timer_status_irq_pkg.sv
/*
 * types shared by the timer status and interrupt-enable register bank
 * assumes: nothing beyond a synthesizable SystemVerilog tool
 */
package timer_status_irq_pkg;

   typedef enum logic [0:0] {seq_idle = 1'h0, seq_second = 1'h1} seq_state_e;

   typedef struct packed {
      logic        valid;
      logic        wr;
      logic        word;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } bus_acc_s;

   typedef struct packed {
      logic wrap_up;
      logic wrap_down;
      logic cmp_a;
      logic cap_a;
      logic cmp_b;
      logic cap_b;
      logic a_is_capture;
      logic b_is_capture;
      logic dma_ack;
   } chan_event_s;

   typedef struct packed {
      logic [2:0] flags;
      logic [2:0] armed;
      logic [2:0] en;
   } chan_state_s;

   typedef struct packed {
      seq_state_e state;
      bus_acc_s   second;
   } seq_state_s;

endpackage

// ===== hw/chan_flag_unit.sv
/*
 * one channel: event flags, read-then-clear arming, interrupt enables
 * assumes: event strobes and bus strobes are on clk_sys
 */
`timescale 1ns/1ns
`default_nettype none
`include "timer_status_irq_cfg.svh"

module chan_flag_unit (
   input  wire logic                              clk_sys,
   input  wire logic                              arst_n,
   input  wire logic                              clk_en,
   input  wire logic                              standby,
   input  wire timer_status_irq_pkg::chan_event_s ev,
   input  wire logic                              down_ok,
   input  wire logic                              dma_ok,
   input  wire logic                              rd_flags,
   input  wire logic                              wr_flags,
   input  wire logic                              wr_enables,
   input  wire logic [7:0]                        wdata,
   output logic [7:0]                             flags_out,
   output logic [7:0]                             enables_out,
   output logic [2:0]                             irq
);
   timer_status_irq_pkg::chan_state_s st_reg, st_next;
   logic [2:0] set_v;
   logic [2:0] clr_v;

   // ==========================================================
   // next state
   always_comb
   begin
      st_next = st_reg;
      set_v = 3'h0;
      clr_v = 3'h0;
      set_v[`TSI_BIT_WRAP] = ev.wrap_up | (ev.wrap_down & down_ok);
      set_v[`TSI_BIT_EVB] = ev.b_is_capture ? ev.cap_b : ev.cmp_b;
      set_v[`TSI_BIT_EVA] = ev.a_is_capture ? ev.cap_a : ev.cmp_a;
      if (rd_flags)
      begin
         st_next.armed = st_reg.armed | st_reg.flags;
      end
      if (wr_flags)
      begin
         clr_v = st_reg.armed & ~wdata[2:0];
      end
      if (ev.dma_ack && dma_ok)
      begin
         clr_v[`TSI_BIT_EVA] = 1'h1;
      end
      // a set in the clear cycle survives and must be read again
      st_next.flags = (st_reg.flags & ~clr_v) | set_v;
      st_next.armed = st_next.armed & ~clr_v & ~set_v;
      if (wr_enables)
      begin
         st_next.en = wdata[2:0];
      end
      if (standby)
      begin
         st_next.flags = 3'(`TSI_FLAGS_RESET);
         st_next.armed = 3'h0;
         st_next.en = 3'(`TSI_ENABLES_RESET);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg <= {3'h0, 3'h0, 3'h0};
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   assign flags_out = {`TSI_RESERVED_ONES, st_reg.flags};
   assign enables_out = {`TSI_RESERVED_ONES, st_reg.en};
   assign irq = st_reg.flags & st_reg.en;
endmodule
`default_nettype wire

// ===== hw/byte_pair_seq.sv
/*
 * splits a word access to an 8-bit register into two byte phases
 * assumes: word accesses use even addresses; same clock as the bus
 */
`timescale 1ns/1ns
`default_nettype none
`include "timer_status_irq_cfg.svh"

module byte_pair_seq (
   input  wire logic                           clk_sys,
   input  wire logic                           arst_n,
   input  wire logic                           clk_en,
   input  wire logic                           hold,
   input  wire timer_status_irq_pkg::bus_acc_s req,
   output logic                                ready,
   output timer_status_irq_pkg::bus_acc_s      acc,
   output logic                                first,
   output logic                                last
);
   timer_status_irq_pkg::seq_state_s st_reg, st_next;
   logic byte_region;

   assign byte_region = req.addr[3:1] == 3'h0;
   assign ready = clk_en && !hold
                  && st_reg.state == timer_status_irq_pkg::seq_idle;

   // ==========================================================
   // phase selection
   always_comb
   begin
      st_next = st_reg;
      acc = req;
      acc.valid = req.valid && ready;
      first = 1'h1;
      last = 1'h1;
      case (st_reg.state)
         timer_status_irq_pkg::seq_idle:
         begin
            if (acc.valid && req.word && byte_region)
            begin
               acc.word = 1'h0;
               acc.addr = {req.addr[7:1], 1'h0};
               last = 1'h0;
               st_next.second = acc;
               st_next.second.addr = {req.addr[7:1], 1'h1};
               st_next.state = timer_status_irq_pkg::seq_second;
            end
         end
         default:
         begin
            acc = st_reg.second;
            acc.valid = clk_en;
            first = 1'h0;
            if (clk_en)
            begin
               st_next.state = timer_status_irq_pkg::seq_idle;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg <= {timer_status_irq_pkg::seq_idle, 27'h0};
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end
endmodule
`default_nettype wire

// ===== hw/timer_status_irq_regs.sv
/*
 * five-channel timer status flags and interrupt enables, with the
 * processor access path for 8-bit and 16-bit timer registers
 * assumes: processor, counters and capture logic all run on clk_sys;
 * 16-bit counter/general/buffer storage sits outside on the wide port
 */
// Function
// - flag register returns to f8 on reset and standby, flags zero
// - upper five bits of both registers read one, ignore writes
// - wrap flag sets on counter wrap up or down
// - downward wrap counts only in phase or complementary modes
// - apart from a dma clear or standby, a flag clears only after being read as one, then written zero
// - writing one to a flag does nothing
// - flag b sets on compare match with general register b
// - flag b sets on capture into general register b
// - flag a sets on compare match or capture of register a
// - on channels 0 to 3 a dma transfer clears flag a
// - wrap request is flag and enable bit 2 together
// - event b request is flag b and enable bit 1 together
// - event a request is flag a and enable bit 0 together
// - enable register resets to f8 on reset and standby
// - five independent flag and enable register pairs
// - 16-bit registers take word and either-byte reads and writes
// - all other registers are eight bits on an 8-bit path
// - a word access to an 8-bit register becomes two byte transfers
`timescale 1ns/1ns
`default_nettype none
`include "timer_status_irq_cfg.svh"

module timer_status_irq_regs (
   input  wire logic                              clk_sys,
   input  wire logic                              arst_n,
   input  wire logic                              clk_en,
   input  wire logic                              standby,
   input  wire timer_status_irq_pkg::bus_acc_s    cpu_req,
   output logic                                   cpu_ready,
   output logic                                   cpu_done,
   output logic [15:0]                            cpu_rdata,
   input  wire timer_status_irq_pkg::chan_event_s ev [`TSI_CHANNELS],
   input  wire logic                              phase_count_sel,
   input  wire logic                              combined_mode_hi,
   input  wire logic                              combined_mode_lo,
   output logic                                   wide_valid,
   output logic                                   wide_wr,
   output logic [2:0]                             wide_chan,
   output logic [2:0]                             wide_idx,
   output logic [1:0]                             wide_be,
   output logic [15:0]                            wide_wdata,
   input  wire logic [15:0]                       wide_rdata,
   output logic [4:0]                             wrap_irq,
   output logic [4:0]                             event_b_irq,
   output logic [4:0]                             event_a_irq
);
   typedef struct packed {
      logic        done;
      logic [15:0] rdata;
      logic        wide_valid;
      logic        wide_wr;
      logic [2:0]  wide_chan;
      logic [2:0]  wide_idx;
      logic [1:0]  wide_be;
      logic [15:0] wide_wdata;
   } top_state_s;

   top_state_s                     st_reg, st_next;
   timer_status_irq_pkg::bus_acc_s acc;
   logic                           acc_first;
   logic                           acc_last;
   logic [2:0]                     acc_chan;
   logic [3:0]                     acc_off;
   logic                           chan_ok;
   logic                           byte_hit;
   logic                           wide_hit;
   logic [7:0]                     bdata;
   logic [7:0]                     byte_rd;
   logic [15:0]                    lane_rd;
   logic [4:0]                     down_ok;
   logic [4:0]                     rd_flags;
   logic [4:0]                     wr_flags;
   logic [4:0]                     wr_enables;
   logic [7:0]                     flags_q [`TSI_CHANNELS];
   logic [7:0]                     en_q [`TSI_CHANNELS];

   // ==========================================================
   // access sequencing
   byte_pair_seq u_seq (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .hold    (st_reg.wide_valid),
      .req     (cpu_req),
      .ready   (cpu_ready),
      .acc     (acc),
      .first   (acc_first),
      .last    (acc_last)
   );

   // ==========================================================
   // address decode
   assign acc_chan = acc.addr[6:4];
   assign acc_off = acc.addr[3:0];
   assign chan_ok = acc.addr[7] == `TSI_ADDR_TOP_BIT
                    && acc_chan < 3'(`TSI_CHANNELS);
   // big-endian lanes: even byte on the upper half of the bus
   assign bdata = acc.addr[0] ? acc.wdata[7:0] : acc.wdata[15:8];

   always_comb
   begin
      byte_hit = 1'h0;
      wide_hit = 1'h0;
      if (!acc.valid || !chan_ok)
      begin
         byte_hit = 1'h0;
      end
      else if (acc_off == `TSI_OFF_FLAGS || acc_off == `TSI_OFF_ENABLES)
      begin
         byte_hit = 1'h1;
      end
      else if (acc_off >= `TSI_OFF_WIDE_LO && acc_off <= `TSI_OFF_WIDE_HI)
      begin
         wide_hit = 1'h1;
      end
   end

   // ==========================================================
   // channels
   genvar gi;
   generate
      for (gi = 0; gi < `TSI_CHANNELS; gi = gi + 1)
      begin : g_chan
         logic hit;
         assign hit = byte_hit && acc_chan == 3'(gi);
         assign rd_flags[gi] = hit && !acc.wr && acc_off == `TSI_OFF_FLAGS;
         assign wr_flags[gi] = hit && acc.wr && acc_off == `TSI_OFF_FLAGS;
         assign wr_enables[gi] = hit && acc.wr
                                 && acc_off == `TSI_OFF_ENABLES;
         if (gi == `TSI_PHASE_CHANNEL)
         begin : g_phase
            assign down_ok[gi] = phase_count_sel;
         end
         else if (gi > `TSI_PHASE_CHANNEL)
         begin : g_cmpl
            assign down_ok[gi] = {combined_mode_hi, combined_mode_lo}
                                 == `TSI_COMPLEMENTARY;
         end
         else
         begin : g_up
            assign down_ok[gi] = 1'h0;
         end

         chan_flag_unit u_chan (
            .clk_sys     (clk_sys),
            .arst_n      (arst_n),
            .clk_en      (clk_en),
            .standby     (standby),
            .ev          (ev[gi]),
            .down_ok     (down_ok[gi]),
            .dma_ok      (1'(`TSI_DMA_CHANNELS >> gi)),
            .rd_flags    (rd_flags[gi]),
            .wr_flags    (wr_flags[gi]),
            .wr_enables  (wr_enables[gi]),
            .wdata       (bdata),
            .flags_out   (flags_q[gi]),
            .enables_out (en_q[gi]),
            .irq         ({wrap_irq[gi], event_b_irq[gi], event_a_irq[gi]})
         );

         property p_standby_defaults;
            @(posedge clk_sys) disable iff (!arst_n)
            clk_en && standby |=> flags_q[gi] == `TSI_FLAGS_RESET
                                  && en_q[gi] == `TSI_ENABLES_RESET;
         endproperty
         a_standby_defaults: assert property (p_standby_defaults)
            else $error("standby did not restore f8");

         property p_reserved_ones;
            @(posedge clk_sys) disable iff (!arst_n)
            wr_enables[gi] && clk_en && !standby
            |=> flags_q[gi][7:3] == 5'h1f && en_q[gi][7:3] == 5'h1f
                && en_q[gi][2:0] == $past(bdata[2:0]);
         endproperty
         a_reserved_ones: assert property (p_reserved_ones)
            else $error("reserved bits not one or enable write lost");

         property p_wrap_sets;
            @(posedge clk_sys) disable iff (!arst_n)
            clk_en && !standby && (ev[gi].wrap_up
                                   || ev[gi].wrap_down && down_ok[gi])
            |=> flags_q[gi][2];
         endproperty
         a_wrap_sets: assert property (p_wrap_sets)
            else $error("wrap did not set wrap flag");

         property p_down_gated;
            @(posedge clk_sys) disable iff (!arst_n)
            clk_en && !flags_q[gi][2] && !ev[gi].wrap_up && !down_ok[gi]
            |=> !flags_q[gi][2];
         endproperty
         a_down_gated: assert property (p_down_gated)
            else $error("wrap flag set without a legal wrap");

         property p_event_a;
            @(posedge clk_sys) disable iff (!arst_n)
            clk_en && !standby && (ev[gi].a_is_capture ? ev[gi].cap_a
                                                       : ev[gi].cmp_a)
            |=> flags_q[gi][0];
         endproperty
         a_event_a: assert property (p_event_a)
            else $error("event a lost");

         property p_event_b;
            @(posedge clk_sys) disable iff (!arst_n)
            clk_en && !standby && (ev[gi].b_is_capture ? ev[gi].cap_b
                                                       : ev[gi].cmp_b)
            |=> flags_q[gi][1];
         endproperty
         a_event_b: assert property (p_event_b)
            else $error("event b lost");

         property p_clear_by_read_write;
            @(posedge clk_sys) disable iff (!arst_n)
            clk_en && flags_q[gi][1] && !standby
            ##1 !flags_q[gi][1]
            |-> $past(wr_flags[gi]) && !$past(bdata[1]);
         endproperty
         a_clear_by_read_write: assert property (p_clear_by_read_write)
            else $error("flag b cleared without a zero write");

         property p_write_one;
            @(posedge clk_sys) disable iff (!arst_n)
            clk_en && wr_flags[gi] && !flags_q[gi][1]
            && !ev[gi].cmp_b && !ev[gi].cap_b |=> !flags_q[gi][1];
         endproperty
         a_write_one: assert property (p_write_one)
            else $error("write set a flag");

         property p_dma_clear;
            @(posedge clk_sys) disable iff (!arst_n)
            clk_en && ev[gi].dma_ack && flags_q[gi][0] && !ev[gi].cmp_a
            && !ev[gi].cap_a && !standby && !wr_flags[gi]
            |=> flags_q[gi][0] == (gi >= 4);
         endproperty
         a_dma_clear: assert property (p_dma_clear)
            else $error("dma clear of flag a wrong for channel");

         property p_irq_gate;
            @(posedge clk_sys) disable iff (!arst_n)
            wrap_irq[gi] == (flags_q[gi][2] && en_q[gi][2])
            && event_b_irq[gi] == (flags_q[gi][1] && en_q[gi][1])
            && event_a_irq[gi] == (flags_q[gi][0] && en_q[gi][0]);
         endproperty
         a_irq_gate: assert property (p_irq_gate)
            else $error("interrupt request not flag and enable");
      end
   endgenerate

   // ==========================================================
   // read data and wide port
   always_comb
   begin
      byte_rd = 8'h00;
      if (byte_hit)
      begin
         byte_rd = acc_off == `TSI_OFF_FLAGS ? flags_q[acc_chan]
                                             : en_q[acc_chan];
      end
      lane_rd = acc.addr[0] ? {8'h00, byte_rd} : {byte_rd, 8'h00};
   end

   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'h0;
      st_next.wide_valid = 1'h0;
      if (st_reg.wide_valid)
      begin
         st_next.done = 1'h1;
         st_next.rdata = wide_rdata
                         & {{8{st_reg.wide_be[1]}}, {8{st_reg.wide_be[0]}}};
      end
      else if (acc.valid && wide_hit)
      begin
         st_next.wide_valid = 1'h1;
         st_next.wide_wr = acc.wr;
         st_next.wide_chan = acc_chan;
         st_next.wide_idx = acc_off[3:1];
         st_next.wide_be = acc.word ? 2'h3 : (acc.addr[0] ? 2'h1 : 2'h2);
         st_next.wide_wdata = acc.wdata;
      end
      else if (acc.valid)
      begin
         // unmapped reads return zero, writes are dropped
         st_next.rdata = acc_first ? lane_rd : (st_reg.rdata | lane_rd);
         st_next.done = acc_last;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg <= '0;
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   assign cpu_done = st_reg.done;
   assign cpu_rdata = st_reg.rdata;
   assign wide_valid = st_reg.wide_valid;
   assign wide_wr = st_reg.wide_wr;
   assign wide_chan = st_reg.wide_chan;
   assign wide_idx = st_reg.wide_idx;
   assign wide_be = st_reg.wide_be;
   assign wide_wdata = st_reg.wide_wdata;

   // ==========================================================
   // bus timing checks
   property p_word_split;
      @(posedge clk_sys) disable iff (!arst_n)
      cpu_req.valid && cpu_ready && cpu_req.word && cpu_req.addr[3:1] == 3'h0
      |=> !cpu_ready && !cpu_done ##1 cpu_done;
   endproperty
   a_word_split: assert property (p_word_split)
      else $error("word to byte register not two transfers");

   property p_wide_access;
      @(posedge clk_sys) disable iff (!arst_n)
      cpu_req.valid && cpu_ready && cpu_req.addr[7] == 1'h0
      && cpu_req.addr[6:4] < 3'h5 && cpu_req.addr[3:0] >= 4'h2
      && cpu_req.addr[3:0] <= 4'hb
      |=> wide_valid
          && wide_be == ($past(cpu_req.word) ? 2'h3
                         : $past(cpu_req.addr[0]) ? 2'h1 : 2'h2)
          ##1 cpu_done;
   endproperty
   a_wide_access: assert property (p_wide_access)
      else $error("wide access lanes or timing wrong");
endmodule
`default_nettype wire

// ===== dv/wide_store.sv
/* outside store of the 16-bit timer registers on the wide port
   assumes: same clk_sys as the register bank, read data combinational */
`timescale 1ns/1ns
`default_nettype none
module wide_store (
   input  wire logic        clk_sys,
   input  wire logic        wide_valid,
   input  wire logic        wide_wr,
   input  wire logic [2:0]  wide_chan,
   input  wire logic [2:0]  wide_idx,
   input  wire logic [1:0]  wide_be,
   input  wire logic [15:0] wide_wdata,
   output logic [15:0]      wide_rdata
);
   // ====================
   // storage
   logic [15:0] mem [64];
   logic [15:0] last_reg;
   wire  [5:0]  sel = {wide_chan, wide_idx};
   // idle cycles show the inverse of the last value, never a stale copy
   assign wide_rdata = wide_valid ? mem[sel] : ~last_reg;
   always_ff @(posedge clk_sys)
   begin
      if (wide_valid)
         last_reg <= wide_rdata;
      if (wide_valid && wide_wr && wide_be[1])
         mem[sel][15:8] <= wide_wdata[15:8];
      if (wide_valid && wide_wr && wide_be[0])
         mem[sel][7:0] <= wide_wdata[7:0];
   end
endmodule
`default_nettype wire

// ===== dv/timer_status_irq_regs_tb.sv
/* self-checking bench of the timer status and enable register bank
   assumes: design files and wide_store compiled before it */
`timescale 1ns/1ns
`default_nettype none
module timer_status_irq_regs_tb;
   // ====================
   // signals
   logic        clk_sys, arst_n, standby, ph_sel, cm_hi, cm_lo;
   logic        cpu_ready, cpu_done, wide_valid, wide_wr;
   logic [15:0] cpu_rdata, wide_wdata, wide_rdata, q;
   logic [2:0]  wide_chan, wide_idx;
   logic [1:0]  wide_be;
   logic [4:0]  wrap_irq, event_b_irq, event_a_irq;
   logic [2:0]  en [5];
   logic [31:0] seed;
   int          fail_count, cmp_count, cyc;
   timer_status_irq_pkg::bus_acc_s    cpu_req;
   timer_status_irq_pkg::chan_event_s ev [5];

   timer_status_irq_regs u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
      .clk_en(1'h1), .standby(standby), .cpu_req(cpu_req),
      .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
      .ev(ev), .phase_count_sel(ph_sel), .combined_mode_hi(cm_hi),
      .combined_mode_lo(cm_lo), .wide_valid(wide_valid), .wide_wr(wide_wr),
      .wide_chan(wide_chan), .wide_idx(wide_idx), .wide_be(wide_be),
      .wide_wdata(wide_wdata), .wide_rdata(wide_rdata),
      .wrap_irq(wrap_irq), .event_b_irq(event_b_irq),
      .event_a_irq(event_a_irq));
   wide_store u_store (.clk_sys(clk_sys), .wide_valid(wide_valid),
      .wide_wr(wide_wr), .wide_chan(wide_chan), .wide_idx(wide_idx),
      .wide_be(wide_be), .wide_wdata(wide_wdata), .wide_rdata(wide_rdata));

   // ====================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] rx(input logic [2:0] b);
      return 8'hf8 | {5'h00, b};
   endfunction
   function automatic logic [7:0] adr(input logic [2:0] c);
      return {1'h0, c, 4'h0};
   endfunction
   task automatic wrap_up;
      if (fail_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until taken; done awaited under a bound
   task automatic acc(input logic w, input logic wd, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] r);
      int n;
      // an edge passes so valid never falls and rises in one step
      @(posedge clk_sys);
      #1 cpu_req = '{1'h1, w, wd, a, d};
      n = 0;
      while (cpu_ready !== 1'h1 && n < 20)
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      @(posedge clk_sys);
      #1 cpu_req.valid = 1'h0;
      n = 0;
      while (cpu_done !== 1'h1 && n < 20)
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      r = cpu_rdata;
      chk({15'h0000, cpu_done}, 16'h0001);
   endtask
   task automatic pulse(input logic [2:0] c, input logic [8:0] e);
      ev[c] = e;
      @(posedge clk_sys);
      #1 ev[c] = '0;
   endtask

   // ====================
   // clock, timeout, sequence
   initial
   begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         wrap_up;
      end
   end
   initial
   begin
      arst_n = 1'h0; standby = 1'h0; ph_sel = 1'h0; cm_hi = 1'h1;
      cm_lo = 1'h1; cpu_req = '0; seed = 32'h00018173;
      for (int c = 0; c < 5; c++) ev[c] = '0;
      repeat (3) @(posedge clk_sys);
      #1 arst_n = 1'h1;
      for (int c = 0; c < 5; c++)
      begin
         acc(0, 1, adr(3'(c)), 0, q);
         chk(q, 16'hf8f8);
         seed = lfsr(seed);
         en[c] = seed[2:0];
         acc(1, 1, adr(3'(c)), seed[15:0], q);
         acc(0, 1, adr(3'(c)), 0, q);
         chk(q, {8'hf8, rx(en[c])});
         pulse(3'(c), c[0] ? 9'h12e : 9'h150);
         acc(0, 0, adr(3'(c)), 0, q);
         chk(q, 16'hff00);
         chk({13'h0, wrap_irq[c], event_b_irq[c], event_a_irq[c]},
             {13'h0, en[c]});
         acc(1, 0, adr(3'(c)), 0, q);
         acc(0, 0, adr(3'(c)), 0, q);
         chk(q, 16'hf800);
         pulse(3'(c), 9'h100);
         acc(1, 0, adr(3'(c)), 0, q);
         acc(0, 0, adr(3'(c)), 0, q);
         chk(q, 16'hfc00);
         acc(1, 0, adr(3'(c)), 0, q);
         // up-only modes: a downward wrap must not raise the flag
         pulse(3'(c), 9'h080);
         acc(0, 0, adr(3'(c)), 0, q);
         chk(q, 16'hf800);
      end
      acc(0, 0, 8'h0e, 0, q);
      chk(q, 16'h0000);
      // down wrap: channel 2 phase mode, channels 3 and 4 complementary
      ph_sel = 1'h1; cm_lo = 1'h0;
      for (int c = 0; c < 5; c++)
      begin
         pulse(3'(c), 9'h080);
         pulse(3'(c), 9'h040);
         pulse(3'(c), 9'h001);
         acc(0, 0, adr(3'(c)), 0, q);
         chk(q, {rx({c >= 2, 1'h0, c == 4}), 8'h00});
      end
      seed = lfsr(seed);
      acc(1, 1, 8'h12, seed[15:0], q);
      acc(1, 0, 8'h13, {8'h00, seed[23:16]}, q);
      acc(0, 1, 8'h12, 0, q);
      chk(q, {seed[15:8], seed[23:16]});
      acc(0, 0, 8'h12, 0, q);
      chk(q, {seed[15:8], 8'h00});
      standby = 1'h1;
      @(posedge clk_sys);
      #1 standby = 1'h0;
      for (int c = 0; c < 5; c++)
      begin
         acc(0, 1, adr(3'(c)), 0, q);
         chk(q, 16'hf8f8);
      end
      wrap_up;
   end
endmodule
`default_nettype wire
